// [rtl/metadata_pkg.sv]
// Overview of operation
// - master switch on appends enabled records to every image; off attaches only the checksum record.
// - image and checksum records enabled from reset; disabling them has no effect.
// - item selector picks one item; enable accesses act on that item only.
// - each item has its own read-write enable; included only when set.
// - while acquisition runs, master switch and enable writes are ignored.
// - checksum computed over image payload, sent in a read-only record.
// - image data record carries the payload itself in the framed output.
// - frame number record holds the image's frame number.
// - horizontal and vertical region shift records sent when enabled.
// - width and height records sent when enabled.
// - exposure time record holds exposure applied for that image.
// - gain selector chooses which gain value the gain record returns.
// - gain record reports selected gain applied for the image.
// - black level selector always holds zero; only the single black level value is returned.
// - black level record reports selected black level for the image.
// - pixel format record carries the delivery pixel format code.
// - capture time record holds the low word of the image timestamp.
// - sequencer set record holds the active sequencer set index.
package metadata_pkg;
	localparam int ITEM_COUNT = 13;
	localparam logic [3:0] ITEM_IMAGE = 4'h0;
	localparam logic [3:0] ITEM_CHECKSUM = 4'h1;
	localparam logic [3:0] ITEM_FRAME = 4'h2;
	localparam logic [3:0] ITEM_HSHIFT = 4'h3;
	localparam logic [3:0] ITEM_VSHIFT = 4'h4;
	localparam logic [3:0] ITEM_WIDTH = 4'h5;
	localparam logic [3:0] ITEM_HEIGHT = 4'h6;
	localparam logic [3:0] ITEM_EXPOSURE = 4'h7;
	localparam logic [3:0] ITEM_GAIN = 4'h8;
	localparam logic [3:0] ITEM_BLACK = 4'h9;
	localparam logic [3:0] ITEM_PIXFMT = 4'hA;
	localparam logic [3:0] ITEM_TIME = 4'hB;
	localparam logic [3:0] ITEM_SEQSET = 4'hC;
	localparam logic [12:0] ENABLE_RESET = 13'h0003;
	localparam logic [12:0] ENABLE_FORCED = 13'h0003;
	// register map, word addresses
	localparam logic [3:0] ADDR_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_PICK = 4'h1;
	localparam logic [3:0] ADDR_ITEM_ON = 4'h2;
	localparam logic [3:0] ADDR_GAIN_PICK = 4'h3;
	localparam logic [3:0] ADDR_BLACK_PICK = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h5;
	localparam logic [3:0] ADDR_LAST_CHECKSUM = 4'h6;
	localparam int CTRL_MASTER_BIT = 0;
	localparam int STAT_RUN_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
	localparam logic [31:0] CRC_POLY = 32'hEDB88320;
	localparam logic [31:0] CRC_XOROUT = 32'hFFFFFFFF;
	localparam logic [1:0] GAIN_PICK_RESET = 2'h0;
	localparam logic [1:0] BLACK_PICK_RESET = 2'h0;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_IMAGE = 4'b0010,
		ST_RECORD = 4'b0100,
		ST_CHECKSUM = 4'b1000
	} frame_state_t;
endpackage

// [rtl/image_metadata_appender.sv]
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
module image_metadata_appender
	import metadata_pkg::*;
#(
	parameter int DATA_W = 32
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic ce_in,
	// register port
	input wire logic [3:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// acquisition state
	input wire logic acq_running_in,
	// per-frame capture values, sampled on frame_start_in
	input wire logic frame_start_in,
	input wire logic [31:0] frame_number_in,
	input wire logic [15:0] region_horizontal_shift_in,
	input wire logic [15:0] region_vertical_shift_in,
	input wire logic [15:0] width_in,
	input wire logic [15:0] height_in,
	input wire logic [31:0] exposure_in,
	input wire logic [31:0] gain_all_in,
	input wire logic [31:0] gain_red_in,
	input wire logic [31:0] gain_green_in,
	input wire logic [31:0] gain_blue_in,
	input wire logic [31:0] black_all_in,
	input wire logic [31:0] pixel_format_in,
	input wire logic [63:0] capture_time_in,
	input wire logic [7:0] sequencer_set_in,
	// image pixel stream
	input wire logic pix_valid_in,
	input wire logic [DATA_W-1:0] pix_data_in,
	input wire logic pix_last_in,
	output logic pix_ready_out,
	// framed output stream
	output logic out_valid_out,
	output logic [DATA_W-1:0] out_data_out,
	output logic [3:0] out_item_out,
	output logic out_last_out,
	input wire logic out_ready_in
);
	import metadata_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// registers
	logic metadata_master_on;
	logic [3:0] metadata_item_pick;
	logic [ITEM_COUNT-1:0] metadata_item_on;
	logic [1:0] gain_pick;
	logic [1:0] black_pick;
	logic [31:0] last_checksum;
	frame_state_t state;

	wire wr_ok = ce_in & reg_wr_in & ~acq_running_in;
	wire wr_control = wr_ok & (reg_addr_in == ADDR_CONTROL);
	wire wr_pick = ce_in & reg_wr_in & (reg_addr_in == ADDR_PICK);
	wire wr_item_on = wr_ok & (reg_addr_in == ADDR_ITEM_ON);
	wire wr_gain_pick = ce_in & reg_wr_in & (reg_addr_in == ADDR_GAIN_PICK);
	wire wr_black_pick = ce_in & reg_wr_in & (reg_addr_in == ADDR_BLACK_PICK);
	wire pick_ok = (reg_wdata_in[3:0] < 4'(ITEM_COUNT));
	wire [ITEM_COUNT-1:0] pick_mask = ITEM_COUNT'(1) << metadata_item_pick;
	// selected-item enable write, forced items always stay on
	wire [ITEM_COUNT-1:0] next_item_on = (reg_wdata_in[0] ? (metadata_item_on | pick_mask)
		: (metadata_item_on & ~pick_mask)) | ENABLE_FORCED;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			metadata_master_on <= 1'b0;
			metadata_item_pick <= ITEM_IMAGE;
			metadata_item_on <= ENABLE_RESET;
			gain_pick <= GAIN_PICK_RESET;
			black_pick <= BLACK_PICK_RESET;
		end else begin
			if (wr_control) begin
				metadata_master_on <= reg_wdata_in[CTRL_MASTER_BIT];
			end
			if (wr_pick && pick_ok) begin
				metadata_item_pick <= reg_wdata_in[3:0];
			end
			if (wr_item_on) begin
				metadata_item_on <= next_item_on;
			end
			if (wr_gain_pick) begin
				gain_pick <= reg_wdata_in[1:0];
			end
			if (wr_black_pick) begin
				// only one black level exists; any other code reads back as zero
				black_pick <= 2'h0;
			end
		end
	end

	// read mux
	wire [31:0] status_word = {30'h0, state != ST_IDLE, acq_running_in};
	logic [31:0] rd_mux;
	always_comb begin
		case (reg_addr_in)
			ADDR_CONTROL: rd_mux = {31'h0, metadata_master_on};
			ADDR_PICK: rd_mux = {28'h0, metadata_item_pick};
			ADDR_ITEM_ON: rd_mux = {31'h0, metadata_item_on[metadata_item_pick]};
			ADDR_GAIN_PICK: rd_mux = {30'h0, gain_pick};
			ADDR_BLACK_PICK: rd_mux = {30'h0, black_pick};
			ADDR_STATUS: rd_mux = status_word;
			ADDR_LAST_CHECKSUM: rd_mux = last_checksum;
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			reg_rdata_out <= 32'h0;
		end else if (ce_in) begin
			reg_rdata_out <= reg_rd_in ? rd_mux : 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// capture snapshot: values frozen at frame start
	logic [31:0] snap [ITEM_COUNT];
	logic [ITEM_COUNT-1:0] snap_on;
	logic [31:0] gain_sel_value;
	always_comb begin
		case (gain_pick)
			2'h0: gain_sel_value = gain_all_in;
			2'h1: gain_sel_value = gain_red_in;
			2'h2: gain_sel_value = gain_green_in;
			default: gain_sel_value = gain_blue_in;
		endcase
	end
	wire [31:0] next_snap [ITEM_COUNT];
	assign next_snap[ITEM_IMAGE] = 32'h0;
	assign next_snap[ITEM_CHECKSUM] = 32'h0;
	assign next_snap[ITEM_FRAME] = frame_number_in;
	assign next_snap[ITEM_HSHIFT] = {16'h0, region_horizontal_shift_in};
	assign next_snap[ITEM_VSHIFT] = {16'h0, region_vertical_shift_in};
	assign next_snap[ITEM_WIDTH] = {16'h0, width_in};
	assign next_snap[ITEM_HEIGHT] = {16'h0, height_in};
	assign next_snap[ITEM_EXPOSURE] = exposure_in;
	assign next_snap[ITEM_GAIN] = gain_sel_value;
	assign next_snap[ITEM_BLACK] = black_all_in;
	assign next_snap[ITEM_PIXFMT] = pixel_format_in;
	// the 64-bit timestamp is cut to its low word to keep one word per record
	assign next_snap[ITEM_TIME] = capture_time_in[31:0];
	assign next_snap[ITEM_SEQSET] = {24'h0, sequencer_set_in};

	wire take_frame = ce_in & frame_start_in & (state == ST_IDLE);
	genvar gi;
	generate
		for (gi = 0; gi < ITEM_COUNT; gi++) begin : g_snap
			always_ff @(posedge clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					snap[gi] <= 32'h0;
				end else if (take_frame) begin
					snap[gi] <= next_snap[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			snap_on <= '0;
		end else if (take_frame) begin
			// master off: no optional records, image and checksum only
			snap_on <= metadata_master_on ? metadata_item_on : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checksum over image words
	logic [31:0] crc;
	function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [DATA_W-1:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < DATA_W; i++) begin
			r = ((r[0] ^ d[i]) ? CRC_POLY : 32'h0) ^ (r >> 1);
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// framer
	logic [3:0] item;
	wire out_free = ~out_valid_out | out_ready_in;
	// the output word still waits for the sink at this edge
	wire out_hold = out_valid_out & ~out_ready_in;
	// ready is registered, so it only rises when the output slot is sure to be empty;
	// this halves the pixel rate but needs no skid buffer
	wire pix_take = ce_in & (state == ST_IMAGE) & pix_valid_in & pix_ready_out;
	// next enabled optional record at or after a position, in selector order
	function automatic logic [4:0] next_item(input logic [ITEM_COUNT-1:0] on, input logic [3:0] from);
		logic [4:0] r;
		r = 5'h1F;
		for (int i = ITEM_COUNT - 1; i >= int'(ITEM_FRAME); i--) begin
			if (on[i] && i >= int'(from)) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction
	wire [4:0] first_rec = next_item(snap_on, ITEM_FRAME);
	wire [4:0] after_rec = next_item(snap_on, item + 4'h1);
	wire [31:0] crc_final = crc ^ CRC_XOROUT;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state <= ST_IDLE;
			item <= ITEM_IMAGE;
			crc <= CRC_INIT;
			last_checksum <= 32'h0;
			out_valid_out <= 1'b0;
			out_data_out <= '0;
			out_item_out <= ITEM_IMAGE;
			out_last_out <= 1'b0;
			pix_ready_out <= 1'b0;
		end else if (ce_in) begin
			if (out_valid_out && out_ready_in) begin
				out_valid_out <= 1'b0;
			end
			case (state)
				ST_IDLE: begin
					if (frame_start_in) begin
						state <= ST_IMAGE;
						crc <= CRC_INIT;
						pix_ready_out <= ~out_hold;
					end
				end
				ST_IMAGE: begin
					pix_ready_out <= ~out_hold & ~pix_take;
					if (pix_take) begin
						out_valid_out <= 1'b1;
						out_data_out <= pix_data_in;
						out_item_out <= ITEM_IMAGE;
						out_last_out <= 1'b0;
						crc <= crc_word(crc, pix_data_in);
						if (pix_last_in) begin
							pix_ready_out <= 1'b0;
							if (first_rec[4]) begin
								state <= ST_CHECKSUM;
							end else begin
								state <= ST_RECORD;
								item <= first_rec[3:0];
							end
						end
					end
				end
				ST_RECORD: begin
					if (out_free) begin
						out_valid_out <= 1'b1;
						out_data_out <= DATA_W'(snap[item]);
						out_item_out <= item;
						out_last_out <= 1'b0;
						if (after_rec[4]) begin
							state <= ST_CHECKSUM;
						end else begin
							item <= after_rec[3:0];
						end
					end
				end
				ST_CHECKSUM: begin
					// checksum record closes every frame, even with the master switch off
					if (out_free) begin
						out_valid_out <= 1'b1;
						out_data_out <= DATA_W'(crc_final);
						out_item_out <= ITEM_CHECKSUM;
						out_last_out <= 1'b1;
						last_checksum <= crc_final;
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end
endmodule

// [test/image_metadata_appender_asserts.sv]
`timescale 1ns/1ps
module image_metadata_appender_asserts #(
	parameter int DATA_W = 32
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic acq_running_in,
	input wire logic pix_valid_in,
	input wire logic [DATA_W-1:0] pix_data_in,
	input wire logic pix_ready_out,
	input wire logic out_valid_out,
	input wire logic [DATA_W-1:0] out_data_out,
	input wire logic [3:0] out_item_out,
	input wire logic out_last_out,
	input wire logic out_ready_in
);
	import metadata_pkg::*;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	rdata_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
		else $error("read data not zero outside a read");
	status_run_a: assert property (reg_rd_in && reg_addr_in == ADDR_STATUS
		|=> reg_rdata_out[STAT_RUN_BIT] == $past(acq_running_in))
		else $error("status does not show acquisition");
	out_hold_a: assert property (out_valid_out && !out_ready_in |=> out_valid_out
		&& $stable(out_data_out) && $stable(out_item_out) && $stable(out_last_out))
		else $error("output word changed while stalled");
	pixel_pass_a: assert property (pix_valid_in && pix_ready_out && out_ready_in
		|=> out_valid_out && out_item_out == ITEM_IMAGE
		&& out_data_out == $past(pix_data_in))
		else $error("pixel not forwarded as image word");
	ready_free_a: assert property (pix_ready_out |-> !out_valid_out)
		else $error("pixel ready while output word pending");
	last_is_crc_a: assert property (out_valid_out && out_last_out
		|-> out_item_out == ITEM_CHECKSUM)
		else $error("last word is not the checksum");
	crc_is_last_a: assert property (out_valid_out && out_item_out == ITEM_CHECKSUM
		|-> out_last_out)
		else $error("checksum word not marked last");
	record_order_a: assert property (out_valid_out && out_ready_in && out_item_out >= ITEM_FRAME
		|=> !out_valid_out || out_item_out > $past(out_item_out)
		|| out_item_out == ITEM_CHECKSUM)
		else $error("records out of order");
	frame_end_a: assert property (out_valid_out && out_ready_in && out_last_out
		|=> !out_valid_out)
		else $error("output continues after last word");
endmodule
bind image_metadata_appender image_metadata_appender_asserts #(.DATA_W(DATA_W)) u_asserts (
	.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out), .acq_running_in(acq_running_in),
	.pix_valid_in(pix_valid_in), .pix_data_in(pix_data_in), .pix_ready_out(pix_ready_out),
	.out_valid_out(out_valid_out), .out_data_out(out_data_out), .out_item_out(out_item_out),
	.out_last_out(out_last_out), .out_ready_in(out_ready_in));

// [test/frame_sink.sv]
`timescale 1ns/1ps
module frame_sink (
	input wire logic clk_in,
	input wire logic stall_in,
	input wire logic valid_in,
	input wire logic [31:0] data_in,
	input wire logic [3:0] item_in,
	input wire logic last_in,
	output logic ready_out
);
	logic [31:0] got_data[$];
	logic [3:0] got_item[$];
	logic got_last[$];
	int n_last = 0;
	initial ready_out = 1'b0;
	// slow mode drops ready every other cycle so words wait mid-frame
	always @(posedge clk_in) begin
		ready_out <= stall_in ? !ready_out : 1'b1;
		if (valid_in && ready_out) begin
			got_data.push_back(data_in);
			got_item.push_back(item_in);
			got_last.push_back(last_in);
			if (last_in) n_last++;
		end
	end
endmodule

// [test/image_metadata_appender_tb_top.sv]
`timescale 1ns/1ps
module image_metadata_appender_tb_top;
	import metadata_pkg::*;
	logic clk_in = 0, rst_b_in = 0, reg_wr_in = 0, reg_rd_in = 0, acq_running_in = 0;
	logic frame_start_in = 0, pix_valid_in = 0, pix_last_in = 0, stall = 0;
	logic [3:0] reg_addr_in = 0;
	logic [31:0] reg_wdata_in = 0, pix_data_in = 0, reg_rdata_out, out_data_out;
	logic [31:0] frame_number_in, exposure_in, gain_all_in, gain_red_in, gain_green_in;
	logic [31:0] gain_blue_in, black_all_in, pixel_format_in;
	logic [15:0] region_horizontal_shift_in, region_vertical_shift_in, width_in, height_in;
	logic [63:0] capture_time_in;
	logic [7:0] sequencer_set_in;
	logic pix_ready_out, out_valid_out, out_last_out, out_ready_in;
	logic [3:0] out_item_out;
	logic [12:0] en = ENABLE_RESET;
	logic master = 0;
	logic [31:0] base = 32'h12340100, gpick = 0, last_crc;
	int n_fail = 0, comparisons = 0;
	image_metadata_appender u_image_metadata_appender (.clk_in, .rst_b_in, .ce_in(1'b1),
		.reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .acq_running_in,
		.frame_start_in, .frame_number_in, .region_horizontal_shift_in,
		.region_vertical_shift_in, .width_in, .height_in, .exposure_in, .gain_all_in,
		.gain_red_in, .gain_green_in, .gain_blue_in, .black_all_in, .pixel_format_in,
		.capture_time_in, .sequencer_set_in, .pix_valid_in, .pix_data_in, .pix_last_in,
		.pix_ready_out, .out_valid_out, .out_data_out, .out_item_out, .out_last_out,
		.out_ready_in);
	frame_sink u_frame_sink (.clk_in, .stall_in(stall), .valid_in(out_valid_out),
		.data_in(out_data_out), .item_in(out_item_out), .last_in(out_last_out),
		.ready_out(out_ready_in));
	initial forever #5 clk_in = !clk_in;
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_in);
		reg_wr_in <= 1'b1; reg_addr_in <= a; reg_wdata_in <= d;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rdchk(input string n, input logic [3:0] a, input logic [31:0] e);
		@(posedge clk_in);
		reg_rd_in <= 1'b1; reg_addr_in <= a;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1 chk(n, e, reg_rdata_out);
	endtask
	task automatic set_item(input int j, input logic on);
		wr(ADDR_PICK, j);
		wr(ADDR_ITEM_ON, {31'h0, on});
		if (!acq_running_in && j > 1) en[j] = on;
	endtask
	task automatic caps(input logic [31:0] b);
		frame_number_in <= b + 32'h2; exposure_in <= b + 32'h7;
		region_horizontal_shift_in <= b[15:0] + 16'h3; region_vertical_shift_in <= b[15:0] + 16'h4;
		width_in <= b[15:0] + 16'h5; height_in <= b[15:0] + 16'h6;
		gain_all_in <= b + 32'h8; gain_red_in <= b + 32'h14;
		gain_green_in <= b + 32'h15; gain_blue_in <= b + 32'h16;
		black_all_in <= b + 32'h9; pixel_format_in <= b + 32'hA;
		capture_time_in <= {32'hC3C3C3C3, b + 32'hB}; sequencer_set_in <= b[7:0] + 8'hC;
	endtask
	function automatic logic [31:0] expv(input int j);
		if (j == ITEM_GAIN) return gpick == 0 ? base + 32'h8 : base + 32'h13 + gpick;
		if (j >= 3 && j <= 6) return {16'h0, base[15:0]} + j;
		if (j == ITEM_SEQSET) return {24'h0, base[7:0]} + j;
		return base + j;
	endfunction
	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] d);
		c = c ^ d;
		for (int b = 0; b < 32; b++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
		return c;
	endfunction
	// sends np pixels, disturbs the capture inputs mid-frame, then checks the whole frame
	task automatic frame(input int np);
		logic [31:0] e[$], c;
		logic [3:0] k[$];
		int want, t;
		want = u_frame_sink.n_last + 1;
		u_frame_sink.got_data.delete(); u_frame_sink.got_item.delete(); u_frame_sink.got_last.delete();
		caps(base);
		@(posedge clk_in) frame_start_in <= 1'b1;
		@(posedge clk_in) frame_start_in <= 1'b0;
		caps(base + 32'h0F0);
		c = CRC_INIT;
		for (int i = 0; i < np; i++) begin
			pix_valid_in <= 1'b1; pix_data_in <= ~base + i; pix_last_in <= (i == np - 1);
			t = 0;
			do begin @(posedge clk_in); t++; end while (pix_ready_out !== 1'b1 && t < 50);
			e.push_back(~base + i); k.push_back(ITEM_IMAGE); c = crc_step(c, ~base + i);
		end
		pix_valid_in <= 1'b0;
		for (int j = 2; j < ITEM_COUNT; j++) if (master && en[j]) begin
			e.push_back(expv(j)); k.push_back(j[3:0]);
		end
		last_crc = c ^ CRC_XOROUT;
		e.push_back(last_crc); k.push_back(ITEM_CHECKSUM);
		for (t = 0; t < 300 && u_frame_sink.n_last < want; t++) @(posedge clk_in);
		chk("words", 32'(e.size()), 32'(u_frame_sink.got_data.size()));
		foreach (e[i]) begin
			chk("data", e[i], u_frame_sink.got_data[i]);
			chk("item", {28'h0, k[i]}, {28'h0, u_frame_sink.got_item[i]});
			chk("last", {31'h0, i == e.size() - 1}, {31'h0, u_frame_sink.got_last[i]});
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		rdchk("control", ADDR_CONTROL, 32'h0);
		set_item(1, 1'b0);
		rdchk("crc on", ADDR_ITEM_ON, 32'h1);
		wr(ADDR_PICK, 2);
		wr(ADDR_PICK, 13);
		rdchk("pick", ADDR_PICK, 32'h2);
		rdchk("frame on", ADDR_ITEM_ON, 32'h0);
		wr(ADDR_BLACK_PICK, 1);
		rdchk("black pick", ADDR_BLACK_PICK, 32'h0);
		rdchk("unmapped", 4'hF, 32'h0);
		$display("test regs done");
	endtask
	task automatic t_plain;
		set_item(3, 1'b1);
		frame(3);
		rdchk("last crc", ADDR_LAST_CHECKSUM, last_crc);
		$display("test master off done");
	endtask
	task automatic t_full;
		wr(ADDR_CONTROL, 1);
		master = 1;
		for (int j = 2; j < ITEM_COUNT; j++) set_item(j, 1'b1);
		stall = 1;
		for (int g = 0; g < 4; g++) begin
			gpick = g;
			base = base + 32'h100;
			wr(ADDR_GAIN_PICK, g);
			rdchk("gain pick", ADDR_GAIN_PICK, gpick);
			frame(g + 1);
		end
		stall = 0;
		$display("test all records done");
	endtask
	task automatic t_frozen;
		@(posedge clk_in) acq_running_in <= 1'b1;
		wr(ADDR_CONTROL, 0);
		set_item(5, 1'b0);
		rdchk("status", ADDR_STATUS, 32'h1);
		frame(1);
		@(posedge clk_in) acq_running_in <= 1'b0;
		set_item(5, 1'b0);
		frame(2);
		$display("test frozen config done");
	endtask
	task automatic stop_test;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		caps(base);
		repeat (10) @(posedge clk_in);
		rst_b_in <= 1'b1;
		t_regs();
		t_plain();
		t_full();
		t_frozen();
		stop_test();
	end
	initial begin
		#100000;
		n_fail++;
		stop_test();
	end
endmodule
